// ---- rtl/ppt_defines.svh ----
// register indices, field positions and fixed timing offsets of the panel timing generator
`ifndef PPT_DEFINES_SVH
`define PPT_DEFINES_SVH

// register indices; byte address on the bus is four times the index
`define PPT_IDX_PANEL_TYPE      6'h10
`define PPT_IDX_AC_RATE         6'h11
`define PPT_IDX_HTOTAL          6'h12
`define PPT_IDX_HACTIVE         6'h14
`define PPT_IDX_HSTART_LO       6'h16
`define PPT_IDX_HSTART_HI       6'h17
`define PPT_IDX_VTOTAL_LO       6'h18
`define PPT_IDX_VTOTAL_HI       6'h19
`define PPT_IDX_VACTIVE_LO      6'h1c
`define PPT_IDX_VACTIVE_HI      6'h1d
`define PPT_IDX_VSTART_LO       6'h1e
`define PPT_IDX_VSTART_HI       6'h1f
`define PPT_IDX_LSYNC_CFG       6'h20
`define PPT_IDX_LSYNC_START_LO  6'h22
`define PPT_IDX_LSYNC_START_HI  6'h23
`define PPT_IDX_FSYNC_CFG       6'h24
`define PPT_IDX_FSYNC_START_LO  6'h26
`define PPT_IDX_FSYNC_START_HI  6'h27
`define PPT_IDX_STATUS          6'h28
`define PPT_IDX_FIRST           6'h10
`define PPT_IDX_LAST            6'h27

// field positions
`define PPT_POL_BIT             7
`define PPT_MODE_LSB            4
`define PPT_TYPE_STN            2'h0

// fixed offsets of the active start, in pixel clocks
`define PPT_HSTART_ADD_STN      11'h016
`define PPT_HSTART_ADD_TFT      11'h005

// reset value of every configuration register
`define PPT_REG_RESET           8'h00

`endif

// ---- rtl/ppt_pkg.sv ----
// types shared by the panel timing generator
package ppt_pkg;

    // data path and shift clock shape, bits 5-4 of the panel type register
    typedef enum logic [1:0] {
        PPT_MONO4  = 2'h0,
        PPT_MONO8  = 2'h1,
        PPT_COLOR4 = 2'h2,
        PPT_RSVD   = 2'h3
    } ppt_mode_type;

    // whole state of the generator
    typedef struct packed {
        logic               sy1;
        logic               sy2;
        logic               sy3;
        logic [9:0]         hcnt;
        logic [9:0]         vcnt;
        logic [5:0]         lcnt;
        logic               act;
        logic               ac;
        logic               lsync;
        logic               fsync;
        logic               shclk;
        logic [7:0]         pdat;
        logic               dreq;
        logic [23:0][7:0]   regs;
        logic               wr_pend;
        logic [5:0]         wr_idx;
        logic [31:0]        rdata;
        logic               rdy;
    } ppt_state_type;

endpackage

// ---- rtl/ppt_timing_gen.sv ----
// passive panel timing generator with an AHB-Lite register slave
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ppt_defines.svh"

// Overview of operation
// R1 - Line length is (horizontal total field plus one) times eight pixel clocks.
// R2 - Frame length is the ten-bit vertical total plus one, in lines.
// R3 - Active pixels are (field plus one) times eight; active lines ten-bit value plus one.
// R4 - Software gives passive panels at least 32 active pixels, in steps of 16.
// R5 - Software gives TFT panels at least 8 active pixels, in steps of 8.
// R6 - Passive active start is the ten-bit start value plus 22 pixel clocks.
// R7 - TFT active start is the ten-bit start value plus 5 pixel clocks.
// R8 - Software keeps start plus active below the total, both directions.
// R9 - Line sync starts at ten-bit value plus one, lasts width field plus one.
// R10 - Frame sync lasts its three-bit width field plus one lines.
// R11 - Generic passive timing uses zero frame sync start and vertical active start.
// R12 - Software puts line sync after active pixels plus 22 and ends it before total.
// R13 - Panel type 00 selects passive operation with both syncs active high; the code takes both polarities from bit 7 of the sync config registers.
// R14 - Line sync polarity bit one gives an active-high pulse.
// R15 - Frame sync polarity bit one gives an active-high pulse.
// R16 - Bias toggle inverts once per frame at zero rate, else every n lines.
// R17 - Frame sync settles before line sync; line sync period equals the total.
// R18 - Bias toggle changes before the line sync rising edge.
// R19 - Mono 4-bit: upper nibble, shift period 4, two low two high.
// R20 - Mono 8-bit: all eight bits, shift period 8, four low four high.
// R21 - Colour 4-bit: shift period one pixel clock, half setup and hold.
// R22 - Shift clock idle and data static outside active pixels and lines.
// R23 - Counters run on the pixel clock and restart at programmed totals.
module ppt_timing_gen
    import ppt_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        pixel_clock,
    input  wire logic [7:0]  pixel_in,
    output logic             pixel_req,
    output logic             line_sync,
    output logic             frame_sync,
    output logic             shift_clock,
    output logic [7:0]       panel_data,
    output logic             ac_bias_toggle
);

    ppt_state_type r;
    ppt_state_type n;

    // a register index exists only where a configuration byte is defined
    function automatic logic idx_mapped(input logic [5:0] idx);
        logic ok;
        ok = (idx >= `PPT_IDX_FIRST) && (idx <= `PPT_IDX_LAST);
        case (idx)
            6'h13, 6'h15, 6'h1a, 6'h1b, 6'h21, 6'h25: ok = 1'b0;
            default: ;
        endcase
        return ok;
    endfunction

    function automatic logic [4:0] slot(input logic [5:0] idx);
        logic [5:0] d;
        d = idx - `PPT_IDX_FIRST;
        return d[4:0];
    endfunction

    // decoded configuration fields
    logic [7:0]   cfg_type;
    logic [7:0]   cfg_rate;
    logic [9:0]   ht_last;
    logic [10:0]  line_active_pixels;
    logic [10:0]  line_active_start;
    logic [9:0]   vt_last;
    logic [10:0]  frame_active_lines;
    logic [10:0]  frame_active_start;
    logic [10:0]  line_pulse_start;
    logic [10:0]  line_pulse_width;
    logic         lpol;
    logic [10:0]  frame_pulse_start;
    logic [10:0]  frame_pulse_width;
    logic         fpol;
    ppt_mode_type mode;

    always_comb begin
        cfg_type = r.regs[slot(`PPT_IDX_PANEL_TYPE)];
        cfg_rate = r.regs[slot(`PPT_IDX_AC_RATE)];
        mode     = ppt_mode_type'(cfg_type[`PPT_MODE_LSB +: 2]);
        ht_last  = {r.regs[slot(`PPT_IDX_HTOTAL)][6:0], 3'h7};                // [R1]
        line_active_pixels      = {1'b0, r.regs[slot(`PPT_IDX_HACTIVE)][6:0], 3'h0} + 11'h008; // [R3]
        line_active_start     = {1'b0, r.regs[slot(`PPT_IDX_HSTART_HI)][1:0],
                    r.regs[slot(`PPT_IDX_HSTART_LO)]};
        // the start offset depends on the panel family
        if (cfg_type[1:0] == `PPT_TYPE_STN) begin
            line_active_start = line_active_start + `PPT_HSTART_ADD_STN;                                  // [R6]
        end else begin
            line_active_start = line_active_start + `PPT_HSTART_ADD_TFT;                                  // [R7]
        end
        vt_last  = {r.regs[slot(`PPT_IDX_VTOTAL_HI)][1:0],
                    r.regs[slot(`PPT_IDX_VTOTAL_LO)]};                          // [R2]
        frame_active_lines      = {1'b0, r.regs[slot(`PPT_IDX_VACTIVE_HI)][1:0],
                    r.regs[slot(`PPT_IDX_VACTIVE_LO)]} + 11'h001;               // [R3]
        frame_active_start     = {1'b0, r.regs[slot(`PPT_IDX_VSTART_HI)][1:0],
                    r.regs[slot(`PPT_IDX_VSTART_LO)]};                          // [R11]
        line_pulse_start      = {1'b0, r.regs[slot(`PPT_IDX_LSYNC_START_HI)][1:0],
                    r.regs[slot(`PPT_IDX_LSYNC_START_LO)]} + 11'h001;           // [R9]
        line_pulse_width      = {4'h0, r.regs[slot(`PPT_IDX_LSYNC_CFG)][6:0]} + 11'h001;     // [R9]
        lpol     = r.regs[slot(`PPT_IDX_LSYNC_CFG)][`PPT_POL_BIT];
        frame_pulse_start      = {1'b0, r.regs[slot(`PPT_IDX_FSYNC_START_HI)][1:0],
                    r.regs[slot(`PPT_IDX_FSYNC_START_LO)]};                     // [R11]
        frame_pulse_width      = {8'h00, r.regs[slot(`PPT_IDX_FSYNC_CFG)][2:0]} + 11'h001;    // [R10]
        fpol     = r.regs[slot(`PPT_IDX_FSYNC_CFG)][`PPT_POL_BIT];
    end

    // position tests for the current pixel
    logic        tick;
    logic        line_end;
    logic        frame_end;
    logic        h_in;
    logic        v_in;
    logic        l_on;
    logic        f_on;
    logic [9:0]  phase;
    logic        load;
    logic        shape;
    logic [5:0]  lnext;
    logic [5:0]  aidx;
    logic [7:0]  rbyte;

    always_comb begin
        tick      = r.sy2 & ~r.sy3;
        line_end  = (r.hcnt == ht_last);
        frame_end = (r.vcnt == vt_last);
        h_in      = ({1'b0, r.hcnt} >= line_active_start) && ({1'b0, r.hcnt} < line_active_start + line_active_pixels);
        v_in      = ({1'b0, r.vcnt} >= frame_active_start) && ({1'b0, r.vcnt} < frame_active_start + frame_active_lines);
        l_on      = ({1'b0, r.hcnt} >= line_pulse_start) && ({1'b0, r.hcnt} < line_pulse_start + line_pulse_width);
        f_on      = ({1'b0, r.vcnt} >= frame_pulse_start) && ({1'b0, r.vcnt} < frame_pulse_start + frame_pulse_width);
        phase     = r.hcnt - line_active_start[9:0];
        lnext     = r.lcnt + 6'h01;
        // shift high in the first half of each period, data changes on its rise
        case (mode)
            PPT_MONO4: begin
                load  = (phase[1:0] == 2'h0);                                    // [R19]
                shape = ~phase[1];
            end
            PPT_MONO8: begin
                load  = (phase[2:0] == 3'h0);                                    // [R20]
                shape = ~phase[2];
            end
            default: begin
                load  = 1'b1;                                                    // [R21]
                shape = 1'b1;
            end
        endcase
    end

    // next state: bus slave, pixel clock sampling, counters and panel outputs
    always_comb begin
        n     = r;
        aidx  = haddr[7:2];
        rbyte = 8'h00;
        if (ce) begin
            n.sy1 = pixel_clock;
            n.sy2 = r.sy1;
            n.sy3 = r.sy2;
            n.rdy = 1'b1;
            n.dreq = 1'b0;
            // data phase of a write; unmapped indices are dropped
            if (r.wr_pend) begin
                if (idx_mapped(r.wr_idx)) begin
                    n.regs[slot(r.wr_idx)] = hwdata[7:0];
                end
                n.wr_pend = 1'b0;
            end
            // address phase; reads see a write that finishes in this same cycle
            if (hsel && hready && htrans[1]) begin
                if (hwrite) begin
                    n.wr_pend = 1'b1;
                    n.wr_idx  = aidx;
                end else begin
                    if (haddr[31:8] == 24'h000000 && idx_mapped(aidx)) begin
                        rbyte = n.regs[slot(aidx)];
                        n.rdata = {24'h000000, rbyte};
                    end else if (haddr[31:8] == 24'h000000 && aidx == `PPT_IDX_STATUS) begin
                        n.rdata = {16'h0000, r.ac, r.act, r.fsync, r.lsync, 2'h0, r.vcnt};
                    end else begin
                        n.rdata = 32'h00000000;
                    end
                end
            end
            // everything on the panel side except the colour shift clock advances once per pixel clock
            if (tick) begin
                n.hcnt = line_end ? 10'h000 : r.hcnt + 10'h001;                  // [R1] [R23]
                if (line_end) begin
                    n.vcnt = frame_end ? 10'h000 : r.vcnt + 10'h001;             // [R2] [R23]
                end
                n.lsync = lpol ? l_on : ~l_on;                                   // [R9] [R14] [R13]
                // frame sync moves only at line start, at least one pixel clock ahead of line sync
                if (r.hcnt == 10'h000) begin
                    n.fsync = fpol ? f_on : ~f_on;                               // [R15] [R17] [R13]
                    // bias flips at line start, always before the line sync rises
                    if (cfg_rate[5:0] == 6'h00) begin
                        if (r.vcnt == 10'h000) begin
                            n.ac = ~r.ac;                                        // [R16] [R18]
                        end
                        n.lcnt = 6'h00;
                    end else if (lnext == cfg_rate[5:0]) begin
                        n.ac   = ~r.ac;                                          // [R16] [R18]
                        n.lcnt = 6'h00;
                    end else begin
                        n.lcnt = lnext;
                    end
                end
                n.act = h_in && v_in;
                // outside the window the shift clock idles low and data holds
                if (h_in && v_in) begin
                    if (mode != PPT_COLOR4) begin
                        n.shclk = shape;                                         // [R19] [R20]
                    end
                    if (load) begin
                        n.dreq = 1'b1;
                        n.pdat = (mode == PPT_MONO8) ? pixel_in
                                                     : {pixel_in[3:0], 4'h0};    // [R19] [R21]
                    end
                end else begin
                    n.shclk = 1'b0;                                              // [R22]
                end
            end
            // colour mode follows the pixel clock level, falling mid-pixel;
            // gated by the next window state so no stray pulse trails the window
            if (mode == PPT_COLOR4) begin
                n.shclk = n.act ? r.sy2 : 1'b0;                                  // [R21] [R22]
            end
        end
    end

    // single register of the whole state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
            r.regs <= {24{`PPT_REG_RESET}};
        end else begin
            r <= n;
        end
    end

    assign hreadyout      = r.rdy;
    assign hresp          = 1'b0 & r.rdy;
    assign hrdata         = r.rdata;
    assign pixel_req      = r.dreq;
    assign line_sync      = r.lsync;
    assign frame_sync     = r.fsync;
    assign shift_clock    = r.shclk;
    assign panel_data     = r.pdat;
    assign ac_bias_toggle = r.ac;

endmodule
`default_nettype wire

// ---- bench/ppt_timing_gen_assertions.sv ----
// port checker for the passive panel timing generator
`timescale 1ns/1ps
`default_nettype none
`include "ppt_defines.svh"
module ppt_timing_checker (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        pixel_clock,
    input wire logic        line_sync,
    input wire logic        frame_sync,
    input wire logic        shift_clock,
    input wire logic [7:0]  panel_data,
    input wire logic        ac_bias_toggle
);
    logic [63:0][7:0] rg;
    logic [5:0]       wa;
    logic [2:0]       sy;
    logic [11:0]      age;
    logic [9:0]       lt, fl, al, sh;
    logic             wp, q, la, fa, tick;
    // quiet only after 4095 cycles without a write, so no measured span straddles a reprogram
    assign q = age == 12'hfff;
    assign tick = sy[1] & ~sy[2];
    assign la = line_sync == rg[`PPT_IDX_LSYNC_CFG][7];
    assign fa = frame_sync == rg[`PPT_IDX_FSYNC_CFG][7];
    // register shadow, pixel ticks and counts since the last sync, bias and shift clock edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {rg, wa, sy, age, lt, fl, al, sh, wp} <= '0;
        end else begin
            wp <= hsel & hready & htrans[1] & hwrite;
            wa <= haddr[7:2];
            if (wp) begin
                rg[wa] <= hwdata[7:0];
            end
            sy <= {sy[1:0], pixel_clock};
            age <= wp ? 12'h0 : age + {11'h0, !q};
            lt <= $rose(la) ? 10'h0 : lt + {9'h0, tick};
            fl <= $rose(fa) ? 10'h0 : fl + {9'h0, $rose(la)};
            al <= $changed(ac_bias_toggle) ? 10'h0 : al + {9'h0, $rose(la)};
            sh <= $changed(shift_clock) ? 10'h0 : sh + {9'h0, tick};
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_lon; q && $rose(la); endsequence
    sequence s_loff; q && $fell(la); endsequence
    sequence s_fon; q && $rose(fa); endsequence
    sequence s_acx; q && $changed(ac_bias_toggle); endsequence
    AST_BUS_OKAY: assert property ($past(hresetn) |-> hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    AST_LINE_PERIOD: assert property (s_lon |-> lt == {rg[`PPT_IDX_HTOTAL][6:0], 3'h0} + 10'h8)
        else $error("line period differs from horizontal total");
    AST_LINE_WIDTH: assert property (s_loff |-> lt == {3'h0, rg[`PPT_IDX_LSYNC_CFG][6:0]} + 10'h1)
        else $error("line pulse width wrong");
    AST_FRAME_PERIOD: assert property (s_fon |->
        fl == {rg[`PPT_IDX_VTOTAL_HI][1:0], rg[`PPT_IDX_VTOTAL_LO]} + 10'h1)
        else $error("frame period differs from vertical total");
    AST_FRAME_WIDTH: assert property (q && $fell(fa) |-> fl == {7'h0, rg[`PPT_IDX_FSYNC_CFG][2:0]} + 10'h1)
        else $error("frame pulse width wrong");
    AST_AC_RATE: assert property (s_acx and rg[`PPT_IDX_AC_RATE][5:0] != 6'h0 |->
        al == {4'h0, rg[`PPT_IDX_AC_RATE][5:0]} && !la)
        else $error("bias toggle not every n lines");
    AST_AC_FRAME: assert property (s_acx and rg[`PPT_IDX_AC_RATE][5:0] == 6'h0 |-> $rose(fa))
        else $error("bias toggle not at frame start");
    AST_SHIFT_IDLE: assert property (q && la |-> $stable(shift_clock) && $stable(panel_data))
        else $error("shift clock or data moved outside window");
    AST_SHIFT_HALF: assert property (q && $fell(shift_clock) && !rg[`PPT_IDX_PANEL_TYPE][5] |->
        sh == (rg[`PPT_IDX_PANEL_TYPE][4] ? 10'h4 : 10'h2))
        else $error("shift clock high phase wrong");
endmodule

bind ppt_timing_gen ppt_timing_checker u_ppt_timing_checker (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .pixel_clock, .line_sync,
    .frame_sync, .shift_clock, .panel_data, .ac_bias_toggle);
`default_nettype wire

// ---- bench/ppt_panel_model.sv ----
// behavioural passive panel that takes data on falling shift edges
`timescale 1ns/1ps
`default_nettype none
module ppt_panel_model (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        line_sync,
    input wire logic        frame_sync,
    input wire logic        shift_clock,
    input wire logic [7:0]  panel_data,
    output logic            rpt,
    output logic [9:0]      lines,
    output logic [15:0]     shifts,
    output logic [7:0]      seen
);
    logic [2:0]  prv;
    logic [9:0]  ln;
    logic [15:0] sf;
    logic [7:0]  dor;
    // syncs read as active high, as passive glass expects; one report per frame
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {prv, ln, sf, dor, rpt, lines, shifts, seen} <= '0;
        end else begin
            prv <= {line_sync, frame_sync, shift_clock};
            rpt <= frame_sync & ~prv[1];
            if (frame_sync & ~prv[1]) begin
                {lines, shifts, seen} <= {ln, sf, dor};
                {ln, sf, dor} <= '0;
            end else begin
                ln <= ln + {9'h0, line_sync & ~prv[2]};
                // a word is latched on each falling shift edge
                if (prv[0] & ~shift_clock) begin
                    sf <= sf + 16'h1;
                    dor <= dor | panel_data;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- bench/ppt_timing_gen_tb.sv ----
// self-checking bench for the passive panel timing generator
`timescale 1ns/1ps
`default_nettype none
module ppt_timing_gen_tb;
    typedef struct packed {
        logic [9:0]  lines;
        logic [15:0] shifts;
        logic [7:0]  data;
        logic [7:0]  mask;
    } ppt_note_type;
    logic         hclk, hresetn, ce, hsel, hwrite, hreadyout, pixel_clock, rpt, rph;
    logic         line_sync, frame_sync, shift_clock, ac_bias_toggle;
    logic [1:0]   htrans;
    logic [2:0]   hsize;
    logic [31:0]  haddr, hwdata, hrdata, v;
    logic [7:0]   pixel_in, panel_data, seen;
    logic [9:0]   lines;
    logic [15:0]  shifts;
    int           mismatches = 0;
    int           compares = 0;
    int           cyc = 0;
    int           i;
    logic [31:0]  rq[$];
    ppt_note_type nq[$];
    ppt_note_type n;
    // 64-pixel line, 32 active from 22, sync 56..59, 5 lines, 3 active
    logic [5:0] ci [18] = '{6'h10, 6'h11, 6'h12, 6'h14, 6'h16, 6'h17, 6'h18, 6'h19, 6'h1c,
                            6'h1d, 6'h1e, 6'h1f, 6'h20, 6'h22, 6'h23, 6'h24, 6'h26, 6'h27};
    logic [7:0] cv [18] = '{8'h00, 8'h00, 8'h07, 8'h03, 8'h00, 8'h00, 8'h04, 8'h00, 8'h02,
                            8'h00, 8'h00, 8'h00, 8'h83, 8'h37, 8'h00, 8'h81, 8'h00, 8'h00};
    ppt_timing_gen u_ppt_timing_gen (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .pixel_clock,
        .pixel_in, .pixel_req(), .line_sync, .frame_sync, .shift_clock, .panel_data,
        .ac_bias_toggle);
    ppt_panel_model u_ppt_panel_model (.hclk, .hresetn, .line_sync, .frame_sync,
        .shift_clock, .panel_data, .rpt, .lines, .shifts, .seen);
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    // pixel clock is unrelated in phase to the bus clock
    initial begin
        pixel_clock = 1'b0;
        #7;
        forever #200 pixel_clock = ~pixel_clock;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t ns: seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        if (mismatches == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // one word transfer; each phase is held until hready is seen high
    task automatic xfer(input logic w, input logic [5:0] idx, input logic [31:0] d);
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, idx, 2'h0};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= w ? d : 32'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
        rq.push_back(exp);
        xfer(1'b0, idx, 32'h0);
    endtask
    task automatic wait_rpt();
        do @(posedge hclk); while (rpt !== 1'b1);
        @(posedge hclk);
    endtask
    // read data taken at the end of its data phase, frame reports as they arrive
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (rph && hreadyout === 1'b1) begin
            check(hrdata, rq.pop_front());
        end
        rph <= htrans == 2'h2 && !hwrite && hreadyout === 1'b1;
        if (rpt === 1'b1 && nq.size() > 0) begin
            n = nq.pop_front();
            check({22'h0, lines}, {22'h0, n.lines});
            check({16'h0, shifts}, {16'h0, n.shifts});
            check({24'h0, seen & n.mask}, {24'h0, n.data});
        end
        if (cyc == 60000) begin
            mismatches++;
            complete_run();
        end
    end
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata, pixel_in, rph} = '0;
        ce = 1'b1;
        hsize = 3'h2;
        v = $urandom(49374);
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        hsel <= 1'b1;
        @(posedge hclk);
        // every place but the status word reads zero after reset, gaps and an unmapped place included
        for (i = 16; i < 42; i++) begin
            if (i == 40) continue;
            rd(i[5:0], 32'h0);
        end
        // random words written and read straight back: only the low byte of mapped places sticks
        for (i = 16; i < 42; i++) begin
            if (i == 40) continue;
            v = $urandom();
            xfer(1'b1, i[5:0], v);
            rd(i[5:0], (i > 39 || i == 19 || i == 21 || i == 26 || i == 27 || i == 33 || i == 37)
                       ? 32'h0 : {24'h0, v[7:0]});
        end
        // each data mode in turn; the middle one steps the bias toggle every two lines
        for (i = 0; i < 3; i++) begin
            for (int k = 0; k < 18; k++) begin
                xfer(1'b1, ci[k], {24'h0, k == 0 ? {2'h0, i[1:0], 4'h0} : (k == 1 && i == 1) ? 8'h02 : cv[k]});
            end
            v = $urandom();
            pixel_in <= v[7:0];
            repeat (3) wait_rpt();
            nq.push_back('{10'h5, i == 0 ? 16'h18 : i == 1 ? 16'h0c : 16'h60,
                           i == 1 ? v[7:0] : 8'h00, i == 1 ? 8'hff : 8'h0f});
            wait_rpt();
        end
        complete_run();
    end
endmodule
`default_nettype wire
